// [verilog/frps_pkg.sv]
`default_nettype none
package frps_pkg;

    // ------------------------------------------------------------------
    // register selects and field layout
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FRPS_SEL_CONTROL,
        FRPS_SEL_KEY,
        FRPS_SEL_TABLE_LOW,
        FRPS_SEL_TABLE_HIGH
    } frps_sel_e;

    localparam int CTL_START_BIT = 15;
    localparam int CTL_PROG_EN_BIT = 14;
    localparam int CTL_SEQ_ERR_BIT = 13;
    localparam int CTL_ERASE_BIT = 6;
    localparam logic [15:0] CTL_RW_MASK = 16'h404f;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [15:0] KEY_RESET = 16'h0000;

    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;

    // ------------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------------
    localparam logic [3:0] OP_BULK = 4'hf;
    localparam logic [3:0] OP_GEN_SEG = 4'hd;
    localparam logic [3:0] OP_SEC_SEG = 4'hc;
    localparam logic [3:0] OP_WORD = 4'h3;
    localparam logic [3:0] OP_PAGE_ROW = 4'h2;
    localparam logic [3:0] OP_ROW = 4'h1;
    localparam logic [3:0] OP_CFG = 4'h0;

    typedef enum logic [2:0] {
        FRPS_ACT_NONE,
        FRPS_ACT_BULK_ERASE,
        FRPS_ACT_SEG_ERASE,
        FRPS_ACT_PAGE_ERASE,
        FRPS_ACT_CFG_ERASE,
        FRPS_ACT_WORD_PROG,
        FRPS_ACT_ROW_PROG,
        FRPS_ACT_CFG_PROG
    } frps_act_e;

    // ------------------------------------------------------------------
    // geometry and timing
    // ------------------------------------------------------------------
    localparam int ROW_WORDS = 64;
    localparam int ROW_AW = 6;
    localparam int CLK_MHZ = 200;
    localparam int OP_TIME_US = 1500;
    localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;

    // one register write from the core
    typedef struct packed {
        logic wr;
        frps_sel_e sel;
        logic [15:0] data;
    } frps_wr_s;

    // request to the flash array
    typedef struct packed {
        logic valid;
        frps_act_e act;
        logic [23:0] addr;
    } frps_op_s;

endpackage
`default_nettype wire

// [verilog/frps_sequencer.sv]
`default_nettype none
// Summary of operation
// - key register write-only, reads zero
// - page erase is code 0010, erase, enable
// - no operation without key sequence
// - start bit runs erase, stalls core
// - row program is code 0001, enable set
// - row program stalls core, start self-clears
// - sixty-four buffered words program one row
// - erase-mode codes decoded, others do nothing
// - program-mode codes decoded, others do nothing
// - error flag marks improper sequence
// - enable clear inhibits every operation
module frps_sequencer
    import frps_pkg::*;
#(
    parameter int OP_CYCLES_P = OP_CYCLES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register writes and read-back from the core
    input wire frps_wr_s core_wr,
    input wire logic [23:0] table_addr,
    output logic [15:0] control_rd,
    output logic [15:0] key_rd,
    // core stall while self-timed operation runs
    output logic core_stall,
    // flash array side
    output frps_op_s flash_op,
    output logic [1535:0] row_data,
    input wire logic flash_done
);

    // ------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------
    logic rst_meta_r, rst_sync_r;

    // two flops so release is clean against the clock
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------------
    function automatic frps_act_e decode_op(input logic erase,
                                            input logic [3:0] op);
        frps_act_e a;
        a = FRPS_ACT_NONE;
        if (erase)
        begin
            unique case (op)
                OP_BULK: a = FRPS_ACT_BULK_ERASE;
                OP_GEN_SEG, OP_SEC_SEG: a = FRPS_ACT_SEG_ERASE;
                OP_PAGE_ROW: a = FRPS_ACT_PAGE_ERASE;
                OP_CFG: a = FRPS_ACT_CFG_ERASE;
                default: a = FRPS_ACT_NONE;
            endcase
        end
        else
        begin
            unique case (op)
                OP_WORD: a = FRPS_ACT_WORD_PROG;
                OP_ROW: a = FRPS_ACT_ROW_PROG;
                OP_CFG: a = FRPS_ACT_CFG_PROG;
                default: a = FRPS_ACT_NONE;
            endcase
        end
        return a;
    endfunction

    logic ctl_wr, key_wr, start_req;
    assign ctl_wr = core_wr.wr && core_wr.sel == FRPS_SEL_CONTROL;
    assign key_wr = core_wr.wr && core_wr.sel == FRPS_SEL_KEY;
    assign start_req = ctl_wr && core_wr.data[CTL_START_BIT];

    // ------------------------------------------------------------------
    // key sequence tracker
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} frps_key_e;
    frps_key_e key_r;

    // any write other than the next key byte drops back to idle
    always_ff @(posedge clock or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
            key_r <= KEY_IDLE;
        else if (key_wr && key_r == KEY_IDLE
                 && core_wr.data[7:0] == KEY_FIRST)
            key_r <= KEY_GOT_FIRST;
        else if (key_wr && key_r == KEY_GOT_FIRST
                 && core_wr.data[7:0] == KEY_SECOND)
            key_r <= KEY_ARMED;
        else if (core_wr.wr)
            key_r <= KEY_IDLE;
    end

    // key bytes are consumed by the tracker only; read-back is zero
    always_ff @(posedge clock or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
            key_rd <= KEY_RESET;
        else
            key_rd <= KEY_RESET;
    end

    // ------------------------------------------------------------------
    // operation sequencer
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_BUSY, SEQ_WAIT} frps_seq_e;
    frps_seq_e seq_r;
    logic [31:0] timer_r;
    logic [23:0] base_addr_r;
    logic launch;
    frps_act_e act_now;

    assign act_now = decode_op(control_rd[CTL_ERASE_BIT], control_rd[3:0]);
    // the start only takes effect on an armed, enabled, idle sequencer
    assign launch = start_req && key_r == KEY_ARMED && seq_r == SEQ_IDLE
                    && control_rd[CTL_PROG_EN_BIT];

    // self-timed run; a no-op code still passes through the stall
    always_ff @(posedge clock or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            seq_r <= SEQ_IDLE;
            timer_r <= 32'h0;
        end
        else
        begin
            unique case (seq_r)
                SEQ_IDLE:
                    if (launch)
                    begin
                        seq_r <= SEQ_BUSY;
                        timer_r <= 32'(OP_CYCLES_P - 1);
                    end
                SEQ_BUSY:
                    if (timer_r == 32'h0)
                        seq_r <= SEQ_WAIT;
                    else
                        timer_r <= timer_r - 32'h1;
                SEQ_WAIT:
                    if (flash_done || flash_op.act == FRPS_ACT_NONE)
                        seq_r <= SEQ_IDLE;
            endcase
        end
    end

    // stall the core for exactly the run
    always_ff @(posedge clock or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
            core_stall <= 1'b0;
        else if (launch)
            core_stall <= 1'b1;
        else if (seq_r == SEQ_WAIT
                 && (flash_done || flash_op.act == FRPS_ACT_NONE))
            core_stall <= 1'b0;
    end

    // one-cycle command to the array, address from the table latch;
    // the whole command has one owner so no field has two drivers
    always_ff @(posedge clock or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
            flash_op <= '0;
        else
        begin
            flash_op.valid <= launch && act_now != FRPS_ACT_NONE;
            if (launch)
            begin
                flash_op.act <= act_now;
                flash_op.addr <= base_addr_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    // start bit is set-only and cleared by hardware at the end
    always_ff @(posedge clock or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
            control_rd <= CTL_RESET;
        else
        begin
            if (ctl_wr && seq_r == SEQ_IDLE)
                control_rd <= (core_wr.data & CTL_RW_MASK)
                              | (control_rd & ~CTL_RW_MASK);
            if (launch)
                control_rd[CTL_START_BIT] <= 1'b1;
            else if (seq_r == SEQ_WAIT && !core_stall)
                control_rd[CTL_START_BIT] <= 1'b0;
            else if (seq_r == SEQ_WAIT
                     && (flash_done || flash_op.act == FRPS_ACT_NONE))
                control_rd[CTL_START_BIT] <= 1'b0;
            // set wins: a bad start always flags, a clean run clears
            if (start_req && !launch)
                control_rd[CTL_SEQ_ERR_BIT] <= 1'b1;
            else if (launch)
                control_rd[CTL_SEQ_ERR_BIT] <= 1'b0;
            else if (ctl_wr && seq_r == SEQ_IDLE)
                control_rd[CTL_SEQ_ERR_BIT] <=
                    core_wr.data[CTL_SEQ_ERR_BIT];
        end
    end

    // ------------------------------------------------------------------
    // holding buffers
    // ------------------------------------------------------------------
    logic [ROW_AW-1:0] slot;
    assign slot = table_addr[ROW_AW:1];

    // low word then high byte per slot; slot comes from table_addr, low write latches base
    always_ff @(posedge clock or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            row_data <= '0;
            base_addr_r <= 24'h0;
        end
        else if (core_wr.wr && seq_r == SEQ_IDLE)
        begin
            if (core_wr.sel == FRPS_SEL_TABLE_LOW)
            begin
                row_data[24*slot +: 16] <= core_wr.data;
                base_addr_r <= table_addr;
            end
            else if (core_wr.sel == FRPS_SEL_TABLE_HIGH)
                row_data[24*slot + 16 +: 8] <= core_wr.data[7:0];
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    unkeyed_start_a: assert property (@(posedge clock)
        disable iff (!rst_sync_r)
        start_req && key_r != KEY_ARMED && seq_r == SEQ_IDLE
        |=> control_rd[CTL_SEQ_ERR_BIT] && !core_stall)
        else $error("unkeyed start was not refused");
    enable_gate_a: assert property (@(posedge clock)
        disable iff (!rst_sync_r)
        start_req && !control_rd[CTL_PROG_EN_BIT] |=> !flash_op.valid)
        else $error("operation issued with enable clear");
    stall_start_a: assert property (@(posedge clock)
        disable iff (!rst_sync_r)
        launch |=> core_stall && control_rd[CTL_START_BIT])
        else $error("stall or start missing after launch");
    start_clear_a: assert property (@(posedge clock)
        disable iff (!rst_sync_r)
        $fell(core_stall) |-> !control_rd[CTL_START_BIT])
        else $error("start bit outlived the stall");
    key_reset_a: assert property (@(posedge clock)
        disable iff (!rst_sync_r)
        launch |=> key_r == KEY_IDLE)
        else $error("key tracker not consumed by start");
    key_read_a: assert property (@(posedge clock)
        disable iff (!rst_sync_r)
        key_rd == 16'h0000)
        else $error("key register read non-zero");
    page_erase_a: assert property (@(posedge clock)
        disable iff (!rst_sync_r)
        launch && control_rd[CTL_ERASE_BIT]
        && control_rd[3:0] == OP_PAGE_ROW
        |=> flash_op.valid && flash_op.act == FRPS_ACT_PAGE_ERASE)
        else $error("page erase not issued");
    row_prog_a: assert property (@(posedge clock)
        disable iff (!rst_sync_r)
        launch && !control_rd[CTL_ERASE_BIT] && control_rd[3:0] == OP_ROW
        |=> flash_op.valid && flash_op.act == FRPS_ACT_ROW_PROG)
        else $error("row program not issued");
    noop_code_a: assert property (@(posedge clock)
        disable iff (!rst_sync_r)
        launch && control_rd[3:0] == OP_WORD && control_rd[CTL_ERASE_BIT]
        |=> !flash_op.valid)
        else $error("no-op code reached the array");

endmodule
`default_nettype wire

// [bench/frps_flash_model.sv]
`default_nettype none
// ----------------------------------------------------------------------
// flash array stand-in: answers each command after a settable delay
// ----------------------------------------------------------------------
module frps_flash_model
    import frps_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // command from the sequencer and answer
    input wire frps_op_s flash_op,
    input wire logic [7:0] dly,
    output logic flash_done,
    // record of what was asked
    output logic [15:0] op_count,
    output frps_act_e last_act,
    output logic [23:0] last_addr
);
    logic [7:0] cnt_r;

    // done rises dly cycles after a command and holds until the next one,
    // so a slow array keeps the core stalled past the timer
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 8'h00;
            flash_done <= 1'b0;
            op_count <= 16'h0000;
            last_act <= FRPS_ACT_NONE;
            last_addr <= 24'h000000;
        end
        else if (flash_op.valid)
        begin
            cnt_r <= dly;
            flash_done <= 1'b0;
            op_count <= op_count + 16'h0001;
            last_act <= flash_op.act;
            last_addr <= flash_op.addr;
        end
        else if (cnt_r != 8'h00)
        begin
            cnt_r <= cnt_r - 8'h01;
            flash_done <= (cnt_r == 8'h01);
        end
    end
endmodule
`default_nettype wire

// [bench/flash_row_program_page_erase_sequencer_test.sv]
`default_nettype none
module flash_row_program_page_erase_sequencer_test
    import frps_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int OP_P = 8;
    logic clock, rst_n, flash_done;
    frps_wr_s core_wr;
    logic [23:0] table_addr, last_addr;
    logic [15:0] control_rd, key_rd, op_count;
    logic core_stall;
    frps_op_s flash_op;
    logic [1535:0] row_data;
    logic [7:0] dly;
    frps_act_e last_act;
    int error_cnt = 0;
    int cmp_count = 0;

    frps_sequencer #(.OP_CYCLES_P(OP_P)) dut (.clock(clock), .rst_n(rst_n),
        .core_wr(core_wr), .table_addr(table_addr),
        .control_rd(control_rd), .key_rd(key_rd), .core_stall(core_stall),
        .flash_op(flash_op), .row_data(row_data), .flash_done(flash_done));
    frps_flash_model model (.clock(clock), .rst_n(rst_n),
        .flash_op(flash_op), .dly(dly), .flash_done(flash_done),
        .op_count(op_count), .last_act(last_act), .last_addr(last_addr));

    // ------------------------------------------------------------------
    // clock, reporting and register writes
    // ------------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one write pulse, then one idle cycle before the next may start
    task automatic wr(input frps_sel_e sel, input logic [15:0] d);
        @(posedge clock);
        #1 core_wr = '{wr: 1'b1, sel: sel, data: d};
        @(posedge clock);
        #1 core_wr.wr = 1'b0;
    endtask

    function automatic frps_act_e exp_act(input logic e, input logic [3:0] c);
        if (e)
            case (c)
                OP_BULK: return FRPS_ACT_BULK_ERASE;
                OP_GEN_SEG, OP_SEC_SEG: return FRPS_ACT_SEG_ERASE;
                OP_PAGE_ROW: return FRPS_ACT_PAGE_ERASE;
                OP_CFG: return FRPS_ACT_CFG_ERASE;
                default: return FRPS_ACT_NONE;
            endcase
        case (c)
            OP_WORD: return FRPS_ACT_WORD_PROG;
            OP_ROW: return FRPS_ACT_ROW_PROG;
            OP_CFG: return FRPS_ACT_CFG_PROG;
            default: return FRPS_ACT_NONE;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // keyed start: setup value, 55h, AAh, then the start bit
    // ------------------------------------------------------------------
    task automatic run_op(input logic [15:0] ctl);
        frps_act_e act;
        logic [15:0] n0;
        int n;
        act = exp_act(ctl[CTL_ERASE_BIT], ctl[3:0]);
        wr(FRPS_SEL_CONTROL, ctl);
        // keys go back to back with nothing in between
        wr(FRPS_SEL_KEY, {8'h00, KEY_FIRST});
        wr(FRPS_SEL_KEY, {8'h00, KEY_SECOND});
        n0 = op_count;
        wr(FRPS_SEL_CONTROL, ctl | 16'h8000);
        @(posedge clock); // core issues nothing after start
        #1 chk(core_stall, 1);
        chk(control_rd[CTL_START_BIT], 1);
        n = 0;
        while (core_stall === 1'b1 && n < 300)
        begin
            @(posedge clock);
            #1 n++;
        end
        if (n >= 300)
        begin
            error_cnt++;
            conclude();
        end
        chk(n >= OP_P, 1);
        if (act != FRPS_ACT_NONE)
            chk(n >= dly, 1);
        chk(control_rd[CTL_START_BIT], 0);
        chk(control_rd[CTL_SEQ_ERR_BIT], 0);
        chk(op_count - n0, act != FRPS_ACT_NONE);
        if (act != FRPS_ACT_NONE)
            chk(last_act, act);
    endtask

    task automatic refused(input logic [15:0] ctl);
        logic [15:0] n0;
        n0 = op_count;
        wr(FRPS_SEL_CONTROL, ctl);
        repeat (2) @(posedge clock);
        #1 chk(core_stall, 0);
        chk(control_rd[CTL_SEQ_ERR_BIT], 1);
        chk(op_count, n0);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic test_reset_key();
        chk(control_rd, CTL_RESET);
        chk(core_stall, 0);
        wr(FRPS_SEL_KEY, 16'hff55);
        @(posedge clock);
        #1 chk(key_rd, KEY_RESET);
    endtask

    // erase the page before refilling one of its rows
    task automatic test_page_then_row();
        logic [23:0] exp;
        dly = 8'h01;
        table_addr = 24'h00c000;
        wr(FRPS_SEL_TABLE_LOW, 16'h0000);
        run_op(16'h4042);
        chk(last_addr, 24'h00c000);
        for (int i = 0; i < ROW_WORDS; i++)
        begin
            table_addr = 24'h00c000 + 24'(2 * i);
            // the bench holds the saved page copy; its first row goes back
            wr(FRPS_SEL_TABLE_LOW, 16'h1000 + 16'(i));
            wr(FRPS_SEL_TABLE_HIGH, {8'h00, 8'(i) ^ 8'ha5});
        end
        for (int i = 0; i < ROW_WORDS; i++)
        begin
            exp = {8'(i) ^ 8'ha5, 16'h1000 + 16'(i)};
            chk({8'h00, row_data[24 * i +: 24]}, {8'h00, exp});
        end
        dly = 8'd20;
        run_op(16'h4001);
    endtask

    task automatic test_codes();
        logic [3:0] codes [7] = '{4'hf, 4'hd, 4'hc, 4'h2, 4'h0, 4'h3, 4'h1};
        dly = 8'h02;
        for (int e = 0; e < 2; e++)
            for (int k = 0; k < 7; k++)
                run_op(16'h4000 | 16'(e << 6) | 16'(codes[k]));
    endtask

    task automatic test_refusals();
        wr(FRPS_SEL_CONTROL, 16'h4001);
        refused(16'hc001);
        wr(FRPS_SEL_KEY, 16'h0055);
        wr(FRPS_SEL_CONTROL, 16'h4001);
        wr(FRPS_SEL_KEY, 16'h00aa);
        refused(16'hc001);
        run_op(16'h4001);
        refused(16'hc001);
        wr(FRPS_SEL_CONTROL, 16'h0042);
        wr(FRPS_SEL_KEY, 16'h0055);
        wr(FRPS_SEL_KEY, 16'h00aa);
        refused(16'h8042);
    endtask

    // reset in the middle of a slow run drops the stall and the flags
    task automatic test_mid_reset();
        dly = 8'd40;
        wr(FRPS_SEL_CONTROL, 16'h4001);
        wr(FRPS_SEL_KEY, {8'h00, KEY_FIRST});
        wr(FRPS_SEL_KEY, {8'h00, KEY_SECOND});
        wr(FRPS_SEL_CONTROL, 16'hc001);
        repeat (2) @(posedge clock);
        #1 chk(core_stall, 1);
        rst_n = 1'b0;
        @(posedge clock);
        #1 chk(core_stall, 0);
        chk(control_rd, CTL_RESET);
        rst_n = 1'b1;
        repeat (3) @(posedge clock);
        #1 chk(control_rd, CTL_RESET);
        dly = 8'h01;
        run_op(16'h4001);
    endtask

    // ------------------------------------------------------------------
    // main sequence: reset held 8 cycles, then synchroniser settles
    // ------------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        core_wr = '0;
        table_addr = 24'h000000;
        dly = 8'h01;
        repeat (8) @(posedge clock);
        #1 rst_n = 1'b1;
        repeat (3) @(posedge clock);
        #1 test_reset_key();
        test_page_then_row();
        test_codes();
        test_refusals();
        test_mid_reset();
        conclude();
    end
endmodule
`default_nettype wire
